// [hw/drive_opt_pkg.sv]
// Package with configuration groups, constants and types for the drive option logic
package drive_opt_pkg;

    // Option jumpers, sampled once at reset release except test_select, which is read live
    typedef struct packed {
        logic ready_fitted;                // Ready output fitted
        logic spindle_speed_ok_enable;     // Spindle-status output fitted
        logic solenoid_jumper;             // In-use controls the solenoid
        logic latch_held_variant;          // Held-latch solenoid variant
        logic plain_energize_variant;      // Plain energize solenoid variant
        logic media_swap_flag;             // Media-swap output fitted
        logic double_side_flag;            // Double-sided output fitted
        logic inhibit_protected_writes;    // Write gate blocked on protected media
        logic permit_all_writes;           // Writes allowed on any media
        logic host_controls_write_current; // Host line selects write current
        logic auto_write_current_by_track; // Track position selects write current
        logic self_test_enable;            // Diagnostic jumper
        logic [3:0] test_select;           // Test-select jumpers (bits 3:0 of the jumper word)
    } straps_t;

    // Host-driven interface lines, active low where marked
    typedef struct packed {
        logic drive_select_n;     // Drive select
        logic in_use_n;           // In-use request
        logic write_gate_n;       // Write gate
        logic write_current_n;    // Host write-current select
    } host_in_t;

    // Drive-internal sensor and position status
    typedef struct packed {
        logic       ready;          // Drive ready
        logic       speed_ok;       // Spindle at speed
        logic       lever_open;     // Door lever open
        logic       second_index;   // Second index hole seen
        logic       write_protect;  // Media write protected
        logic       sector_hole;    // Index sensor pulse
        logic [6:0] track;          // Current head track
    } sensors_t;

    localparam logic [6:0] WC_SWITCH_TRACK = 7'h2b;  // Track 43
    localparam logic [4:0] TEST_COUNT      = 5'h10;  // Sixteen diagnostic tests
    localparam logic       OUT_IDLE        = 1'h1;   // Inactive level of low-true outputs

endpackage

// [hw/drive_options.sv]
// Option-dependent interface status and control logic of the flexible disk drive
// Operation
// - Ready and spindle-status outputs each need their option
// - No solenoid jumper: latch solenoid when selected
// - Plain variant energizes solenoid while in-use low
// - Held variant latches until select edge sees in-use high
// - Lever open sets media-swap until next deselect
// - Media-swap output only when its option fitted
// - Second index hole drives double-sided low when selected
// - Double-sided output only when its option fitted
// - Write-inhibit option blocks write gate on protected media
// - Permit-all-writes allows writing, still reports protection
// - Host write-current option follows host line
// - Automatic write-current switches at track 43
// - Diagnostic mode selects one of sixteen tests
// - Diagnostic entry only via jumper at power-up
// - Sector pulses come from the index sensor
// - Drive select is active low, enables the drive
`timescale 1ns/1ps
module drive_options (
    input  wire logic                    clk_sys,          // 250 MHz system clock
    input  wire logic                    srst,             // Synchronous reset, active high
    input  wire drive_opt_pkg::straps_t  straps,           // Option jumpers
    input  wire drive_opt_pkg::host_in_t host_in,          // Host interface lines
    input  wire drive_opt_pkg::sensors_t sensors,          // Drive sensors
    output logic                         ready_n,          // Ready, low true
    output logic                         ready_oe,         // Ready driven onto interface
    output logic                         speed_ok_n,       // Spindle-status, low true
    output logic                         speed_ok_oe,      // Spindle-status driven (shares motor_input_three)
    output logic                         media_swap_n,     // Media-swap, low true
    output logic                         media_swap_oe,    // Media-swap driven
    output logic                         double_side_n,    // Double-sided, low true
    output logic                         double_side_oe,   // Double-sided driven
    output logic                         write_protect_n,  // Write-protect status, low true
    output logic                         write_enable,     // Write circuitry enabled
    output logic                         high_current,     // Reduced/alternate write current select
    output logic                         solenoid_on,      // Lever-lock solenoid drive
    output logic                         sector_pulse,     // Index/sector pulse toward timing logic
    output logic                         self_test_mode,   // Diagnostic mode active
    output logic [3:0]                   test_number       // Selected diagnostic test
);

    // Captured jumpers; all option decoding except test_select reads only these after release
    drive_opt_pkg::straps_t cfg_ff;
    logic                   cfg_taken_ff;

    // Select history and latched lever events
    logic                   sel_prev_ff;
    logic                   held_ff;
    logic                   swap_pend_ff;

    // Decoded select and its edges
    logic                   selected;
    logic                   sel_rise;
    logic                   sel_fall;

    // Select is low true; edges are taken from the registered previous level
    assign selected = ~host_in.drive_select_n;
    assign sel_rise = selected & ~sel_prev_ff;
    assign sel_fall = ~selected & sel_prev_ff;

    // Jumpers caught once after reset release; later changes are ignored until the next reset, except test_select, which test_number follows live
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            cfg_ff       <= '0;
            cfg_taken_ff <= 1'h0;
        end
        else if (!cfg_taken_ff)
        begin
            cfg_ff       <= straps;
            cfg_taken_ff <= 1'h1;
        end
    end

    // Previous select level for edge detection
    // Resets to the unselected idle level, so a released reset never fakes a deselect edge
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            sel_prev_ff <= 1'h0;
        else
            sel_prev_ff <= selected;
    end

    // Ready and spindle-status, independent options; host must not use motor_input_three meanwhile
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ready_n     <= drive_opt_pkg::OUT_IDLE;
            ready_oe    <= 1'h0;
            speed_ok_n  <= drive_opt_pkg::OUT_IDLE;
            speed_ok_oe <= 1'h0;
        end
        else
        begin
            ready_oe    <= cfg_ff.ready_fitted;
            speed_ok_oe <= cfg_ff.spindle_speed_ok_enable;
            ready_n     <= ~(cfg_ff.ready_fitted & selected & sensors.ready);
            speed_ok_n  <= ~(cfg_ff.spindle_speed_ok_enable & selected & sensors.speed_ok);
        end
    end

    // Held-latch state: set on in-use with select, cleared only by a select edge seeing in-use high
    // Deselecting with in-use still low keeps the lever locked, so the host must release it on purpose
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            held_ff <= 1'h0;
        else if (sel_rise && host_in.in_use_n)
            held_ff <= 1'h0;
        else if (selected && !host_in.in_use_n)
            held_ff <= 1'h1;
    end

    // Solenoid drive per lever-lock variant
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            solenoid_on <= 1'h0;
        else if (!cfg_ff.solenoid_jumper)
            solenoid_on <= selected;
        else if (cfg_ff.latch_held_variant)
            solenoid_on <= held_ff | (selected & ~host_in.in_use_n);
        else if (cfg_ff.plain_energize_variant)
            solenoid_on <= ~host_in.in_use_n;
        else
            solenoid_on <= 1'h0;
    end

    // Media-swap pending: lever open sets it, end of the next select clears; set wins
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            swap_pend_ff <= 1'h0;
        else if (sensors.lever_open)
            swap_pend_ff <= 1'h1;
        else if (sel_fall)
            swap_pend_ff <= 1'h0;
    end

    // Select-gated media-swap and double-sided outputs
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            media_swap_n   <= drive_opt_pkg::OUT_IDLE;
            media_swap_oe  <= 1'h0;
            double_side_n  <= drive_opt_pkg::OUT_IDLE;
            double_side_oe <= 1'h0;
        end
        else
        begin
            media_swap_oe  <= cfg_ff.media_swap_flag;
            media_swap_n   <= ~(cfg_ff.media_swap_flag & selected & swap_pend_ff);
            double_side_oe <= cfg_ff.double_side_flag;
            double_side_n  <= ~(cfg_ff.double_side_flag & selected & sensors.second_index);
        end
    end

    // Write lockout and write-protect status; status is reported in every write option
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            write_enable    <= 1'h0;
            write_protect_n <= drive_opt_pkg::OUT_IDLE;
        end
        else
        begin
            write_protect_n <= ~(selected & sensors.write_protect);
            if (cfg_ff.inhibit_protected_writes && !cfg_ff.permit_all_writes)
                write_enable <= selected & ~host_in.write_gate_n & ~sensors.write_protect;
            else
                write_enable <= selected & ~host_in.write_gate_n;
        end
    end

    // Write-current select: host line or track position; neither option keeps normal current
    // Unsigned compare: every track from the switch point inward uses the alternate current
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            high_current <= 1'h0;
        else if (cfg_ff.host_controls_write_current)
            high_current <= ~host_in.write_current_n;
        else if (cfg_ff.auto_write_current_by_track)
            high_current <= (sensors.track >= drive_opt_pkg::WC_SWITCH_TRACK);
        else
            high_current <= 1'h0;
    end

    // Sector timing passes the index sensor through one register
    // The register keeps the output on a flip-flop at the cost of one cycle of index delay
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            sector_pulse <= 1'h0;
        else
            sector_pulse <= sensors.sector_hole;
    end

    // Diagnostic mode fixed from reset; test code follows the select jumpers
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            self_test_mode <= 1'h0;
            test_number    <= 4'h0;
        end
        else
        begin
            self_test_mode <= cfg_ff.self_test_enable;
            test_number    <= cfg_ff.self_test_enable ? straps.test_select : 4'h0;
        end
    end

endmodule

// [tb/host_ctrl_model.sv]
// Host controller model driving the drive interface lines
`timescale 1ns/1ps
module host_ctrl_model (
    input  wire logic               sel,     // Select request
    input  wire logic               use_req, // In-use request
    input  wire logic               wgate,   // Write request
    input  wire logic               wcur,    // Write current request
    output drive_opt_pkg::host_in_t host_in  // Interface lines
);
    // Lines are low true; motor input three is never driven, it may carry spindle status
    assign host_in = {~sel, ~use_req, ~wgate, ~wcur};
endmodule

// [tb/drive_options_props.sv]
// Checker of the drive option port relations
`timescale 1ns/1ps
module drive_options_props (
    input wire logic                    clk_sys,         // Clock
    input wire logic                    srst,            // Reset
    input wire drive_opt_pkg::straps_t  straps,          // Jumpers
    input wire drive_opt_pkg::host_in_t host_in,         // Host lines
    input wire drive_opt_pkg::sensors_t sensors,         // Sensors
    input wire logic                    ready_oe,        // Ready driven
    input wire logic                    media_swap_n,    // Media swap
    input wire logic                    media_swap_oe,   // Media swap driven
    input wire logic                    double_side_n,   // Double sided
    input wire logic                    write_enable,    // Write enabled
    input wire logic                    high_current,    // Write current
    input wire logic                    solenoid_on,     // Solenoid
    input wire logic                    self_test_mode   // Diagnostic mode
);
    logic [1:0] age_ff; // Cycles since reset release
    logic       ok;
    // Jumpers are trusted only after capture has reached the outputs
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            age_ff <= 2'h0;
        else if (age_ff != 2'h3)
            age_ff <= age_ff + 2'h1;
    end
    assign ok = (age_ff == 2'h3);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_ready_oe_fit: assert property (ok |-> ready_oe == straps.ready_fitted)
        else $error("ready drive differs from option");
    a_swap_oe_fit: assert property (ok |-> media_swap_oe == straps.media_swap_flag)
        else $error("media swap drive differs from option");
    a_unsel_idle: assert property (host_in.drive_select_n [*2] |=> media_swap_n && double_side_n)
        else $error("gated output low while unselected");
    a_dside_sel: assert property (ok && straps.double_side_flag && !host_in.drive_select_n
        && sensors.second_index |=> !double_side_n)
        else $error("double sided not reported");
    a_write_block: assert property (ok && straps.inhibit_protected_writes && !straps.permit_all_writes
        && sensors.write_protect |=> !write_enable)
        else $error("write on protected media");
    a_track_current: assert property (ok && straps.auto_write_current_by_track
        && !straps.host_controls_write_current
        |=> high_current == ($past(sensors.track) >= drive_opt_pkg::WC_SWITCH_TRACK))
        else $error("write current not by track");
    a_no_jumper_lock: assert property (ok && !straps.solenoid_jumper && !host_in.drive_select_n
        |=> solenoid_on)
        else $error("solenoid off while selected");
    a_diag_entry: assert property (ok && !straps.self_test_enable |-> !self_test_mode)
        else $error("diagnostic mode without jumper");
    c_diag: cover property (ok && self_test_mode);
    c_swap: cover property (ok && !media_swap_n);
    c_held: cover property (ok && solenoid_on && straps.latch_held_variant);
endmodule
bind drive_options drive_options_props chk_u (.*);

// [tb/drive_options_tb_top.sv]
// Self-checking testbench of the drive option logic
`timescale 1ns/1ps
module drive_options_tb_top;
    logic                     clk_sys = 1'b0;
    logic                     srst    = 1'b1;
    logic [15:0]              st      = 16'h0000; // Jumpers, ready at bit 15
    logic                     sel     = 1'b0;
    logic                     use_req = 1'b0;
    logic                     wg      = 1'b0;
    logic                     wc      = 1'b0;
    drive_opt_pkg::sensors_t  sn      = '0;
    drive_opt_pkg::host_in_t  hi;
    logic                     r_n, r_oe, s_n, s_oe, m_n, m_oe, d_n, d_oe, wp_n, we, hc, sol, stm, sp;
    logic [3:0]               tn;
    int                       num_errors  = 0;
    int                       comparisons = 0;
    always #2 clk_sys = ~clk_sys;
    host_ctrl_model host_u (.sel(sel), .use_req(use_req), .wgate(wg), .wcur(wc), .host_in(hi));
    drive_options dut_u (.clk_sys(clk_sys), .srst(srst), .straps(st), .host_in(hi), .sensors(sn),
        .ready_n(r_n), .ready_oe(r_oe), .speed_ok_n(s_n), .speed_ok_oe(s_oe), .media_swap_n(m_n),
        .media_swap_oe(m_oe), .double_side_n(d_n), .double_side_oe(d_oe), .write_protect_n(wp_n),
        .write_enable(we), .high_current(hc), .solenoid_on(sol), .sector_pulse(sp),
        .self_test_mode(stm), .test_number(tn));
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Jumpers other than test_select only count when present across a reset
    task automatic rst(input logic [15:0] s);
        st = s;
        srst = 1'b1;
        step(2);
        srst = 1'b0;
        step(3);
    endtask
    task automatic test_done;
        if (num_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic test_opts;
        rst(16'hef40);
        sn.ready = 1'b1;
        sn.speed_ok = 1'b1;
        sel = 1'b1; use_req = 1'b1; step(2);
        chk("ready_oe", 1, r_oe);
        chk("ready_n", 0, r_n);
        chk("speed_ok_n", 0, s_n);
        chk("speed_ok_oe", 1, s_oe);
        chk("double_side_oe", 1, d_oe);
        chk("solenoid_on", 1, sol);
        use_req = 1'b0; sn.second_index = 1'b1; step(2);
        chk("solenoid_on", 0, sol);
        chk("double_side_n", 0, d_n);
        sel = 1'b0; step(2);
        chk("double_side_n", 1, d_n);
        chk("ready_n", 1, r_n);
        sn.second_index = 1'b0;
        rst(16'h0000);
        sel = 1'b1; step(2);
        chk("ready_oe", 0, r_oe);
        chk("media_swap_oe", 0, m_oe);
        chk("double_side_oe", 0, d_oe);
        chk("solenoid_on", 1, sol);
        chk("ready_n", 1, r_n);
        chk("speed_ok_n", 1, s_n);
        sn.sector_hole = 1'b1;
        step(1);
        chk("sector_pulse", 1, sp);
        sn.sector_hole = 1'b0;
        step(1);
        chk("sector_pulse", 0, sp);
    endtask
    task automatic test_swap;
        rst(16'hef40);
        chk("media_swap_oe", 1, m_oe);
        sn.lever_open = 1'b1; step(1); sn.lever_open = 1'b0; step(5);
        chk("media_swap_n", 0, m_n);
        sel = 1'b0; step(2);
        chk("media_swap_n", 1, m_n);
        sel = 1'b1; step(2);
        chk("media_swap_n", 1, m_n);
    endtask
    // Held latch must survive deselect and clear only on a select edge seeing in-use high
    task automatic test_latch;
        rst(16'hb000);
        use_req = 1'b1; step(2);
        chk("solenoid_on", 1, sol);
        chk("ready_n", 0, r_n);
        chk("speed_ok_n", 1, s_n);
        use_req = 1'b0; sel = 1'b0; step(3);
        chk("solenoid_on", 1, sol);
        sel = 1'b1; step(3);
        chk("solenoid_on", 0, sol);
    endtask
    task automatic test_write;
        rst(16'hef40);
        wg = 1'b1; sn.write_protect = 1'b1; step(2);
        chk("write_enable", 0, we);
        sn.write_protect = 1'b0; wc = 1'b1; step(2);
        chk("write_enable", 1, we);
        chk("high_current", 1, hc);
        wc = 1'b0; step(2);
        chk("high_current", 0, hc);
        rst(16'h00a0);
        sn.write_protect = 1'b1; sn.track = 7'h2a; step(2);
        chk("write_enable", 1, we);
        chk("write_protect_n", 0, wp_n);
        chk("high_current", 0, hc);
        sn.track = 7'h2b; step(2);
        chk("high_current", 1, hc);
        sel = 1'b0;
        step(2);
        chk("write_protect_n", 1, wp_n);
        chk("write_enable", 0, we);
        wg = 1'b0; sn.write_protect = 1'b0;
    endtask
    task automatic test_diag;
        rst(16'h001a);
        chk("self_test_mode", 1, stm);
        chk("test_number", 4'ha, tn);
        for (int i = 0; i < int'(drive_opt_pkg::TEST_COUNT); i++)
        begin
            st = {12'h001, i[3:0]}; // Diagnostic jumper stays fitted while tests are picked
            step(2);
            chk("test_number", i[3:0], tn);
        end
        chk("self_test_mode", 1, stm);
        rst(16'h0005);
        chk("self_test_mode", 0, stm);
        chk("test_number", 0, tn);
    endtask
    initial
    begin
        test_opts();
        test_swap();
        test_latch();
        test_write();
        test_diag();
        test_done();
    end
    // About 110 cycles of tests; cut off well beyond that
    initial
    begin
        #20000;
        num_errors++;
        test_done();
    end
endmodule
